/* File: pstm_board.sv */
// Purpose: board straps and backplane traffic seen by the strap block
// Assumes: ones are board pull-ups, zeros the weak internal pull-downs
// Notes:   once transceivers face inward the lines change every cycle
`timescale 1ns/1ns
module pstm_board
   import pstm_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 out_enable_n,
   input  wire logic [PSTM_VA_W-1:0] va_strap,
   input  wire logic [PSTM_VD_W-1:0] vd_strap,
   output logic      [PSTM_VA_W-1:0] vme_address_lines,
   output logic      [PSTM_VD_W-1:0] vme_data_lines
);
   logic [PSTM_VA_W-1:0] traffic_r = '0;

   // ---------------------------------------------------------------
   // line levels
   // ---------------------------------------------------------------
   // no slave access is aimed at the device; lines only carry noise
   always_ff @(posedge pclk) begin
      traffic_r <= traffic_r + 31'h1;
   end

   // a late capture sees inverted, moving levels instead of the straps
   always_comb begin
      if (out_enable_n) begin
         vme_address_lines = va_strap;
         vme_data_lines    = vd_strap;
      end else begin
         vme_address_lines = ~va_strap ^ traffic_r;
         vme_data_lines    = ~vd_strap ^ traffic_r[4:0];
      end
   end
endmodule // pstm_board

/* File: pstm_core.sv */
// Purpose: strap capture, option load, bus width and test mode decode
// Assumes: strap, reset and test pins are asynchronous to pclk
// Notes:   pclk stands for both reference and PCI clocks here
// Notes on behaviour
// - strap enables default image, 256MB base/bound, mem or io, vme space
// - default image: zero offset, no posted writes, 32-bit non-block data
// - strap picks memory or io space for internal registers
// - sample 64-bit request pin each PCI reset; high means 32-bit
// - on 32-bit bus drive extension pins continuously
// - address bit 1 low: first base io, second memory
// - address bit 1 high: first base memory, second io
// - second space bit inverse of first, fixed until power-on
// - transceivers disabled during reset so straps float to pull level
// - capture straps within two clocks, enable transceivers one later
// - load options into registers clocks after all resets released
// - latch three test-mode inputs at reset and hold them
// - decode test-mode code into eight modes
// - nand tree: latch in power-on reset, fast timers, tristate outputs; code latches at any reset
// - high impedance: latch in power-on reset, tristate outputs; code latches at any reset
// - reference clock drives vme side; system clock out when controller
// - later resets restore power-on options; width and syscon resampled
`timescale 1ns/1ns
module pstm_core
   import pstm_pkg::*;
#(
   parameter int LOAD_CYC = PSTM_LOAD_CYC
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 clk_en,
   input  wire logic                 power_on_reset_n,
   input  wire logic                 vme_sys_reset_n,
   input  wire logic                 pci_reset_n,
   input  wire logic [PSTM_VA_W-1:0] vme_address_lines,
   input  wire logic [PSTM_VD_W-1:0] vme_data_lines,
   input  wire logic                 req64_n_in,
   input  wire logic                 syscon_strap_n,
   input  wire logic [2:0]           tmode_in,
   input  wire logic                 sysfail_req,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic                      vme_transceiver_out_enable_n,
   output logic                      pci_csr_base_first,
   output logic                      pci_csr_base_second,
   output logic                      pci_64bit,
   output logic                      ext64_drive,
   output logic                      syscon_en,
   output logic                      vme_system_clock_out,
   output logic                      outputs_tristate,
   output logic                      timers_fast,
   output logic                      sysfail_driver_output,
   output pstm_image_t               image_cfg,
   output pstm_tmode_t               test_mode
);

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   localparam int SW = PSTM_VA_W + PSTM_VD_W + 3 + 3 + 1;
   logic [SW-1:0] s1_r;
   logic [SW-1:0] s2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else if (clk_en) begin
         s1_r <= {vme_address_lines, vme_data_lines, power_on_reset_n,
                  vme_sys_reset_n, pci_reset_n, tmode_in, req64_n_in};
         s2_r <= s1_r;
      end
   end
   logic [PSTM_VA_W-1:0] va_s;
   logic [PSTM_VD_W-1:0] vd_s;
   logic                 por_n_s;
   logic                 sys_n_s;
   logic                 pci_n_s;
   logic [2:0]           tm_s;
   logic                 req64_s;
   assign {va_s, vd_s, por_n_s, sys_n_s, pci_n_s, tm_s, req64_s} = s2_r;

   logic syscon_s1_r;
   logic syscon_s2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         syscon_s1_r <= 1'b0;
         syscon_s2_r <= 1'b0;
      end else if (clk_en) begin
         syscon_s1_r <= syscon_strap_n;
         syscon_s2_r <= syscon_s1_r;
      end
   end

   logic any_rst;
   assign any_rst = !por_n_s || !sys_n_s || !pci_n_s;

   // ----------------------------------------------------------------
   // power-on sequencer
   // ----------------------------------------------------------------
   pstm_state_t state_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= PSTM_ST_RESET;
      end else if (clk_en) begin
         case (state_r)
            PSTM_ST_RESET:   if (por_n_s) state_r <= PSTM_ST_CAPTURE;
            PSTM_ST_CAPTURE: state_r <= PSTM_ST_ENABLE;
            PSTM_ST_ENABLE:  state_r <= PSTM_ST_RUN;
            PSTM_ST_RUN:     if (!por_n_s) state_r <= PSTM_ST_RESET;
            default:         state_r <= PSTM_ST_RESET;
         endcase
      end
   end

   // straps float while transceivers are off; reset holds them off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vme_transceiver_out_enable_n <= 1'b1;
      end else if (clk_en) begin
         vme_transceiver_out_enable_n <=
            !(state_r == PSTM_ST_ENABLE || state_r == PSTM_ST_RUN);
      end
   end

   // captured once per power-on; other resets leave it alone
   pstm_opts_t cap_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_r <= '0;
      end else if (clk_en && state_r == PSTM_ST_CAPTURE) begin
         cap_r.image.en        <= va_s[PSTM_TI_EN_BIT];
         cap_r.image.io_space  <= va_s[PSTM_TI_LAS_BIT];
         cap_r.image.vme_space <= va_s[PSTM_TI_VAS_HI:PSTM_TI_VAS_LO];
         cap_r.image.base      <= va_s[PSTM_TI_BS_HI:PSTM_TI_BS_LO];
         cap_r.image.bound     <= va_s[PSTM_TI_BD_HI:PSTM_TI_BD_LO];
         cap_r.csr_first_io    <= !va_s[PSTM_CSR_SP_BIT];
         cap_r.data_opts       <= vd_s;
      end
   end

   // ----------------------------------------------------------------
   // load into configuration registers after all resets clear
   // ----------------------------------------------------------------
   logic [PSTM_CNT_W-1:0] load_cnt_r;
   logic                  loaded_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_cnt_r <= PSTM_CNT_ZERO;
         loaded_r   <= 1'b0;
      end else if (clk_en) begin
         if (any_rst || state_r != PSTM_ST_RUN) begin
            load_cnt_r <= PSTM_CNT_ZERO;
            loaded_r   <= 1'b0;
         end else if (!loaded_r) begin
            if (load_cnt_r == PSTM_CNT_W'(LOAD_CYC - 1)) begin
               loaded_r <= 1'b1;
            end
            load_cnt_r <= load_cnt_r + PSTM_CNT_ONE;
         end
      end
   end

   logic load_pulse;
   assign load_pulse = clk_en && state_r == PSTM_ST_RUN && !any_rst
                       && !loaded_r && load_cnt_r == PSTM_CNT_W'(LOAD_CYC - 1);

   pstm_opts_t cfg_r;
   logic       img_en_sw_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= '0;
      end else if (load_pulse) begin
         cfg_r <= cap_r;
      end
   end

   // ----------------------------------------------------------------
   // bus width resampled on each PCI reset, system controller on each VME system reset
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pci_64bit <= 1'b0;
      end else if (clk_en && !pci_n_s) begin
         pci_64bit <= !req64_s;
      end
   end
   assign ext64_drive = !pci_64bit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         syscon_en <= 1'b0;
      end else if (clk_en && !sys_n_s) begin
         syscon_en <= !syscon_s2_r;
      end
   end

   // system clock out is the reference divided by two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vme_system_clock_out <= 1'b0;
      end else if (clk_en) begin
         vme_system_clock_out <= syscon_en && !vme_system_clock_out;
      end
   end

   // ----------------------------------------------------------------
   // test mode latch
   // ----------------------------------------------------------------
   pstm_tmode_t tm_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tm_r <= PSTM_TM_NORMAL;
      end else if (clk_en && any_rst) begin
         tm_r <= pstm_tmode_t'(tm_s);
      end
   end
   assign test_mode = tm_r;

   always_comb begin
      outputs_tristate = 1'b0;
      timers_fast      = 1'b0;
      case (tm_r)
         PSTM_TM_ACCEL:  timers_fast = 1'b1;
         PSTM_TM_NAND: begin
            timers_fast      = 1'b1;
            outputs_tristate = 1'b1;
         end
         PSTM_TM_HIZ:    outputs_tristate = 1'b1;
         default:        outputs_tristate = 1'b0;
      endcase
   end

   // sysfail stays live in every mode so a failed board is still seen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sysfail_driver_output <= 1'b0;
      end else if (clk_en) begin
         sysfail_driver_output <= sysfail_req;
      end
   end

   // ----------------------------------------------------------------
   // configuration outputs
   // ----------------------------------------------------------------
   assign pci_csr_base_first  = cfg_r.csr_first_io;
   assign pci_csr_base_second = !cfg_r.csr_first_io;
   always_comb begin
      image_cfg    = cfg_r.image;
      image_cfg.en = cfg_r.image.en & img_en_sw_r;
   end

   // ----------------------------------------------------------------
   // apb slave, zero wait states
   // ----------------------------------------------------------------
   logic wr_en;
   assign wr_en   = clk_en && psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         img_en_sw_r <= 1'b1;
      end else if (load_pulse) begin
         img_en_sw_r <= 1'b1;
      end else if (wr_en && paddr == PSTM_ADDR_IMG) begin
         img_en_sw_r <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         case (paddr)
            PSTM_ADDR_OPT:  prdata <= {14'h0000, cfg_r};
            PSTM_ADDR_IMG:  prdata <= {PSTM_TI_OFFSET[31:21],
                                       PSTM_TI_GRAN_SH, PSTM_TI_MAXW32,
                                       1'b0, 1'b0, 1'b0,
                                       image_cfg.base, image_cfg.bound,
                                       image_cfg.vme_space,
                                       image_cfg.io_space, image_cfg.en};
            PSTM_ADDR_STAT: prdata <= {20'h00000, state_r, loaded_r,
                                       pci_64bit, syscon_en,
                                       outputs_tristate, timers_fast, 1'b0,
                                       tm_r, img_en_sw_r};
            PSTM_ADDR_DATA: prdata <= {27'h0000000, cap_r.data_opts};
            PSTM_ADDR_ID:   prdata <= PSTM_ID_VALUE;
            default:        prdata <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking chk_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence por_release_s;
      clk_en && state_r == PSTM_ST_CAPTURE;
   endsequence

   csr_inverse_a: assert property (
      pci_csr_base_second == !pci_csr_base_first)
      else $error("csr space bits not inverse");
   oe_reset_a: assert property (
      (clk_en && state_r == PSTM_ST_RESET) |=> vme_transceiver_out_enable_n)
      else $error("transceivers enabled in reset");
   oe_enable_a: assert property (
      por_release_s ##1 clk_en |=> !vme_transceiver_out_enable_n)
      else $error("transceivers not enabled after capture");
   capture_a: assert property (
      por_release_s |=> cap_r.csr_first_io == !$past(va_s[PSTM_CSR_SP_BIT]))
      else $error("strap not captured");
   load_a: assert property (
      load_pulse |=> cfg_r == $past(cap_r) && loaded_r)
      else $error("options not loaded");
   // first edge after reset release finds the design still held
   width_a: assert property (
      (presetn && clk_en && !pci_n_s) |=> pci_64bit == !$past(req64_s))
      else $error("bus width wrong");
   ext_drive_a: assert property (
      !pci_64bit |-> ext64_drive)
      else $error("extension not driven on 32-bit bus");
   tristate_a: assert property (
      outputs_tristate == (tm_r == PSTM_TM_NAND || tm_r == PSTM_TM_HIZ))
      else $error("tristate decode wrong");
   fast_timers_a: assert property (
      timers_fast == (tm_r == PSTM_TM_ACCEL || tm_r == PSTM_TM_NAND))
      else $error("timer speed decode wrong");
   tmode_hold_a: assert property (
      (!any_rst ##1 !any_rst) |-> $stable(tm_r))
      else $error("test mode changed without reset");
   sysclk_a: assert property (
      (clk_en && !syscon_en) |=> !vme_system_clock_out)
      else $error("system clock out while not controller");

endmodule // pstm_core

/* File: pstm_core_tb_top.sv */
// Purpose: self-checking bench for strap capture and test-mode latch
// Assumes: one clock stands for reference and PCI clocks
// Notes:   straps change between scenarios to expose stale captures
`timescale 1ns/1ns
module pstm_core_tb_top;
   import pstm_pkg::*;
   localparam int LOAD = 4;
   localparam logic [30:0] VA_A = {18'h2AAAA, 13'b1_1_10_1010_0101_0};
   localparam logic [30:0] VA_B = {18'h15555, 13'b0_0_01_0011_1100_1};
   localparam logic [31:0] OPT_A = {14'h0000, VA_A[12:1], ~VA_A[0],
                                    VA_A[4:0] ^ 5'h0F};
   localparam logic [31:0] IMG_A = {PSTM_TI_OFFSET[31:21], PSTM_TI_GRAN_SH,
                                    PSTM_TI_MAXW32, 3'h0, VA_A[8:1],
                                    VA_A[10:9], VA_A[11], VA_A[12]};
   localparam logic [31:0] STAT_RUN = {20'h00000, PSTM_ST_RUN, 10'h201};
   logic              pclk, presetn, clk_en, por_n, sys_n, pci_n;
   logic              req64_n, syscon_n, sysfail_req;
   logic              psel, penable, pwrite, pready, pslverr, oe_n;
   logic              bs_first, bs_second, pci_64bit, ext64, syscon_en;
   logic              sysclk, tristate, fast, sysfail_out;
   logic [2:0]        tmode;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [30:0]       va_s, va;
   logic [4:0]        vd_s, vd;
   pstm_image_t       image_cfg;
   pstm_tmode_t       test_mode;
   int                n_fail, samples_checked;

   pstm_board pstm_board_i (.pclk(pclk), .out_enable_n(oe_n),
      .va_strap(va_s), .vd_strap(vd_s), .vme_address_lines(va),
      .vme_data_lines(vd));

   pstm_core #(.LOAD_CYC(LOAD)) pstm_core_i (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .power_on_reset_n(por_n), .vme_sys_reset_n(sys_n),
      .pci_reset_n(pci_n), .vme_address_lines(va), .vme_data_lines(vd),
      .req64_n_in(req64_n), .syscon_strap_n(syscon_n), .tmode_in(tmode),
      .sysfail_req(sysfail_req), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .vme_transceiver_out_enable_n(oe_n), .pci_csr_base_first(bs_first),
      .pci_csr_base_second(bs_second), .pci_64bit(pci_64bit),
      .ext64_drive(ext64), .syscon_en(syscon_en),
      .vme_system_clock_out(sysclk), .outputs_tristate(tristate),
      .timers_fast(fast), .sysfail_driver_output(sysfail_out),
      .image_cfg(image_cfg), .test_mode(test_mode));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // slave answers at once, but the wait lasts until pready comes
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic resets(input logic por, input int n);
      @(posedge pclk);
      por_n <= ~por;
      sys_n <= 1'b0;
      pci_n <= 1'b0;
      repeat (n) @(posedge pclk);
      por_n <= 1'b1;
      sys_n <= 1'b1;
      pci_n <= 1'b1;
   endtask

   task automatic power_up(input logic [30:0] v);
      int k;
      va_s <= v;
      vd_s <= v[4:0] ^ 5'h0F;
      resets(1'b1, 4);
      @(negedge pclk);
      check("oe_n at release", 32'h1, oe_n);
      k = 0;
      while (oe_n !== 1'b0 && k < 12) begin
         @(negedge pclk);
         k++;
      end
      check("oe_n fall in time", 32'h1, k <= 7);
      repeat (2 + LOAD + 4) @(posedge pclk);
      @(negedge pclk);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_strap_mem();
      power_up(VA_B);
      check("image", VA_B[12:1], image_cfg);
      check("first base space", 32'h0, bs_first);
      check("second base space", 32'h1, bs_second);
      check("syscon off", 32'h0, syscon_en);
   endtask

   task automatic t_strap_io();
      power_up(VA_A);
      check("image", VA_A[12:1], image_cfg);
      check("first base space", 32'h1, bs_first);
      check("second base space", 32'h0, bs_second);
      check("width 64", 32'h0, pci_64bit);
      check("ext drive", 32'h1, ext64);
      apb(1'b0, PSTM_ADDR_ID, 32'h0, rd);
      check("id", PSTM_ID_VALUE, rd);
      apb(1'b0, PSTM_ADDR_OPT, 32'h0, rd);
      check("opt word", OPT_A, rd);
      apb(1'b0, PSTM_ADDR_IMG, 32'h0, rd);
      check("image word", IMG_A, rd);
      apb(1'b0, PSTM_ADDR_STAT, 32'h0, rd);
      check("status word", STAT_RUN, rd);
      apb(1'b0, PSTM_ADDR_DATA, 32'h0, rd);
      check("data straps", {27'h0, VA_A[4:0] ^ 5'h0F}, rd & 32'h1F);
      apb(1'b1, 12'h020, 32'hFFFFFFFF, rd);
      apb(1'b0, 12'h020, 32'h0, rd);
      check("unmapped", 32'h0, rd);
      apb(1'b1, PSTM_ADDR_IMG, 32'h0, rd);
      @(negedge pclk);
      check("image off by software", 32'h0, image_cfg.en);
      apb(1'b1, PSTM_ADDR_IMG, 32'h1, rd);
   endtask

   // straps now read differently; power-on values must come back
   task automatic t_restore();
      logic s;
      @(posedge pclk);
      va_s     <= VA_B;
      req64_n  <= 1'b0;
      syscon_n <= 1'b0;
      resets(1'b0, 4);
      repeat (2 + LOAD + 4) @(posedge pclk);
      @(negedge pclk);
      check("image kept", VA_A[12:1], image_cfg);
      check("first base kept", 32'h1, bs_first);
      check("width 64", 32'h1, pci_64bit);
      check("ext drive", 32'h0, ext64);
      check("syscon on", 32'h1, syscon_en);
      s = sysclk;
      @(negedge pclk);
      check("system clock toggles", 32'h1, s !== sysclk);
      @(posedge pclk);
      clk_en <= 1'b0;
      @(negedge pclk);
      s = sysclk;
      @(negedge pclk);
      check("clock frozen", s, sysclk);
      @(posedge pclk);
      clk_en <= 1'b1;
   endtask

   // board keeps pll select per mode; this bench has no such pin
   task automatic t_modes();
      for (int c = 0; c < 8; c++) begin
         @(posedge pclk);
         tmode       <= c[2:0];
         sysfail_req <= c[0];
         resets(1'b0, 3);
         repeat (4) @(posedge pclk);
         @(negedge pclk);
         check("mode", c, test_mode);
         check("tristate", c == 4 || c == 6, tristate);
         check("fast timers", c == 4 || c == 1, fast);
         check("sysfail drive", c[0], sysfail_out);
      end
      @(posedge pclk);
      tmode <= 3'b100;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      check("mode held", 32'h7, test_mode);
   endtask

   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      por_n = 1'b0;
      sys_n = 1'b0;
      pci_n = 1'b0;
      req64_n = 1'b1;
      syscon_n = 1'b1;
      sysfail_req = 1'b0;
      tmode = 3'b000;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      va_s = VA_B;
      vd_s = 5'h00;
      n_fail = 0;
      samples_checked = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_strap_mem();
      t_strap_io();
      t_restore();
      t_modes();
      give_verdict();
   end

   // whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      give_verdict();
   end
endmodule // pstm_core_tb_top

/* File: pstm_pkg.sv */
// Purpose: constants and types for the power-up strap and test-mode block
// Assumes: single clock domain on pclk
// Notes:   strap bit positions follow the option pin groups
package pstm_pkg;

   // ----------------------------------------------------------------
   // strap positions on the address and data lines
   // ----------------------------------------------------------------
   localparam int PSTM_VA_W        = 31;
   localparam int PSTM_VD_W        = 5;
   localparam int PSTM_TI_EN_BIT   = 12;
   localparam int PSTM_TI_LAS_BIT  = 11;
   localparam int PSTM_TI_VAS_HI   = 10;
   localparam int PSTM_TI_VAS_LO   = 9;
   localparam int PSTM_TI_BS_HI    = 8;
   localparam int PSTM_TI_BS_LO    = 5;
   localparam int PSTM_TI_BD_HI    = 4;
   localparam int PSTM_TI_BD_LO    = 1;
   localparam int PSTM_CSR_SP_BIT  = 0;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] PSTM_ADDR_OPT   = 12'h000;
   localparam logic [11:0] PSTM_ADDR_IMG   = 12'h004;
   localparam logic [11:0] PSTM_ADDR_STAT  = 12'h008;
   localparam logic [11:0] PSTM_ADDR_DATA  = 12'h00C;
   localparam logic [11:0] PSTM_ADDR_ID    = 12'h010;
   localparam logic [31:0] PSTM_ID_VALUE   = 32'h00005A5A; // arbitrary value

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int PSTM_CAPTURE_CYC = 2;
   localparam int PSTM_LOAD_CYC    = 4;
   localparam int PSTM_CNT_W       = 3;
   localparam logic [PSTM_CNT_W-1:0] PSTM_CNT_ZERO = 3'h0;
   localparam logic [PSTM_CNT_W-1:0] PSTM_CNT_ONE  = 3'h1;

   // ----------------------------------------------------------------
   // default image fixed attributes
   // ----------------------------------------------------------------
   localparam logic [31:0] PSTM_TI_OFFSET  = 32'h00000000;
   localparam logic [1:0]  PSTM_TI_MAXW32  = 2'h2;
   localparam logic [3:0]  PSTM_TI_GRAN_SH = 4'hC;

   typedef enum logic [2:0] {
      PSTM_TM_NORMAL = 3'b000,
      PSTM_TM_ACCEL  = 3'b001,
      PSTM_TM_PLL    = 3'b010,
      PSTM_TM_SCAN   = 3'b011,
      PSTM_TM_NAND   = 3'b100,
      PSTM_TM_RAM    = 3'b101,
      PSTM_TM_HIZ    = 3'b110,
      PSTM_TM_RSVD   = 3'b111
   } pstm_tmode_t;

   typedef enum logic [1:0] {
      PSTM_ST_RESET   = 2'b00,
      PSTM_ST_CAPTURE = 2'b01,
      PSTM_ST_ENABLE  = 2'b10,
      PSTM_ST_RUN     = 2'b11
   } pstm_state_t;

   typedef struct packed {
      logic       en;
      logic       io_space;
      logic [1:0] vme_space;
      logic [3:0] base;
      logic [3:0] bound;
   } pstm_image_t;

   typedef struct packed {
      pstm_image_t image;
      logic        csr_first_io;
      logic [4:0]  data_opts;
   } pstm_opts_t;

endpackage
